/* File: include/ccu_defines.svh */
/*
  Constants for the checksum calculation unit: offsets, reset values, polynomial, timing.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// --------------------------------------------------------------------------
// register map (byte offsets)
// --------------------------------------------------------------------------
`define CCU_OFS_DATA      8'h00
`define CCU_OFS_SCRATCH   8'h04
`define CCU_OFS_CTRL      8'h08

// --------------------------------------------------------------------------
// reset values and fields
// --------------------------------------------------------------------------
`define CCU_DATA_RST      32'hFFFFFFFF
`define CCU_SCRATCH_RST   8'h00
`define CCU_ZERO32        32'h00000000
`define CCU_ZERO24        24'h000000
`define CCU_ZERO31        31'h00000000
`define CCU_CTRL_RESET_BIT 0
`define CCU_POLY          32'h04C11DB7

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define CCU_CALC_CYCLES   3'h4
`define CCU_BITS_PER_STEP 8
`define CCU_CNT_ONE       3'h1

`endif

/* File: include/ccu_pkg.sv */
/*
  Types of the checksum calculation unit.
  Assumes ccu_defines.svh is on the include path.
*/
package ccu_pkg;
  `include "ccu_defines.svh"

  // bus request carried as one bundle
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ccu_req_s;

  typedef enum logic [1:0] {
    CCU_IDLE = 2'h0,
    CCU_CALC = 2'h1
  } ccu_state_e;
endpackage

/* File: rtl/ccu_step.sv */
/*
  One slice of the checksum engine: folds eight data bits, msb first, into the running value.
  Assumes purely combinational use inside the main unit.
*/
`timescale 1ns/1ps
`include "ccu_defines.svh"
module ccu_step
  import ccu_pkg::*;
(
  // running value and data slice
  input  wire logic [31:0] crc_i,
  input  wire logic [7:0]  data_i,
  // folded value
  output logic      [31:0] crc_o
);
  always_comb begin
    logic [31:0] c;
    c = crc_i;
    for (int b = `CCU_BITS_PER_STEP - 1; b >= 0; b--) begin
      if (c[31] ^ data_i[b]) begin
        c = {c[30:0], 1'b0} ^ `CCU_POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    crc_o = c;
  end
endmodule // ccu_step

/* File: rtl/ccu_top.sv */
/*
  Checksum calculation unit: data, scratch and control registers on a simple word bus.
  Assumes a bus master on ref_clk_i that holds a request while wait_o is high, using
  only full word transfers.
*/
`timescale 1ns/1ps
`include "ccu_defines.svh"
module ccu_top
  import ccu_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // register bus
  input  wire ccu_req_s    req_i,
  output logic      [31:0] rdata_o,
  output logic             wait_o,
  output logic             err_o
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  ccu_state_e  state_ff, nxt_state;
  logic [31:0] crc_ff, nxt_crc;
  logic [31:0] word_ff, nxt_word;
  logic [2:0]  cnt_ff, nxt_cnt;
  logic [7:0]  scratch_ff, nxt_scratch;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        err_ff, nxt_err;
  logic [31:0] step_out;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire hit_data    = req_i.addr == `CCU_OFS_DATA;
  wire hit_scratch = req_i.addr == `CCU_OFS_SCRATCH;
  wire hit_ctrl    = req_i.addr == `CCU_OFS_CTRL;
  wire hit_any     = hit_data | hit_scratch | hit_ctrl;
  wire busy        = state_ff == CCU_CALC;
  // any access waits while busy: a read must not see a half folded value
  wire take        = req_i.sel & ~busy;
  wire wr_data     = take & req_i.write & hit_data;
  wire wr_scratch  = take & req_i.write & hit_scratch;
  wire wr_reset    = take & req_i.write & hit_ctrl & req_i.wdata[`CCU_CTRL_RESET_BIT];
  wire [7:0] slice = word_ff[31:24];
  wire last_step   = cnt_ff == `CCU_CALC_CYCLES;
  // accepted reads by target; named so the checks below stay readable
  wire rd_take     = take & ~req_i.write;
  wire rd_data     = rd_take & hit_data;
  wire rd_scratch  = rd_take & hit_scratch;
  wire rd_ctrl     = rd_take & hit_ctrl;

  ccu_step u_step (
    .crc_i  (crc_ff),
    .data_i (slice),
    .crc_o  (step_out)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_crc     = crc_ff;
    nxt_word    = word_ff;
    nxt_cnt     = cnt_ff;
    nxt_scratch = scratch_ff;
    unique case (state_ff)
      CCU_IDLE: begin
        if (wr_data) begin
          nxt_word  = req_i.wdata;
          nxt_cnt   = `CCU_CNT_ONE;
          nxt_state = CCU_CALC;
        end
      end
      CCU_CALC: begin
        nxt_crc  = step_out;
        nxt_word = {word_ff[23:0], 8'h00};
        nxt_cnt  = cnt_ff + `CCU_CNT_ONE;
        if (last_step) begin
          nxt_state = CCU_IDLE;
        end
      end
      default: nxt_state = CCU_IDLE;
    endcase
    // control reset bit is a pulse: it is never stored, so it reads back zero
    if (wr_reset) begin
      nxt_crc = `CCU_DATA_RST;
    end
    if (wr_scratch) begin
      nxt_scratch = req_i.wdata[7:0];
    end
  end

  // reads; the ctrl register always reads zero
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err   = 1'b0;
    if (take) begin
      nxt_err = ~hit_any;
      if (!req_i.write) begin
        if (hit_data) begin
          nxt_rdata = crc_ff;
        end else if (hit_scratch) begin
          nxt_rdata = {`CCU_ZERO24, scratch_ff};
        end else begin
          nxt_rdata = `CCU_ZERO32;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // calculation engine
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_ff   <= CCU_IDLE;
      crc_ff     <= `CCU_DATA_RST;
      word_ff    <= `CCU_ZERO32;
      cnt_ff     <= 3'h0;
    end else begin
      state_ff   <= nxt_state;
      crc_ff     <= nxt_crc;
      word_ff    <= nxt_word;
      cnt_ff     <= nxt_cnt;
    end
  end

  // bus side; the scratch byte has its own write enable so a reload never reaches it
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      scratch_ff <= `CCU_SCRATCH_RST;
      rdata_ff   <= `CCU_ZERO32;
      err_ff     <= 1'b0;
    end else begin
      scratch_ff <= nxt_scratch;
      rdata_ff   <= nxt_rdata;
      err_ff     <= nxt_err;
    end
  end

  assign wait_o  = req_i.sel & busy;
  assign rdata_o = rdata_ff;
  assign err_o   = err_ff;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // --------------------------------------------------------------------------
  // handshake checks
  // --------------------------------------------------------------------------
  write_stall_a: assert property (busy && req_i.sel |-> wait_o)
    else $error("access not stalled while busy");
  // a stall shown while idle would hold a master up for nothing
  wait_idle_a: assert property (!busy |-> !wait_o)
    else $error("wait raised while idle");
  read_crc_a: assert property (rd_data |=> rdata_o == $past(crc_ff))
    else $error("data read not checksum");
  // read data must stand until the next accepted read
  read_hold_a: assert property (!rd_take |=> $stable(rdata_o))
    else $error("read data changed without a read");
  ctrl_read_zero_a: assert property (rd_ctrl |=> rdata_o == `CCU_ZERO32)
    else $error("control not reading zero");

  // --------------------------------------------------------------------------
  // calculation checks
  // --------------------------------------------------------------------------
  calc_four_cyc_a: assert property (wr_data |=> busy [*4] ##1 !busy)
    else $error("calculation not four cycles");
  write_lands_a: assert property (wr_data |=> busy && cnt_ff == `CCU_CNT_ONE)
    else $error("data write did not start calculation");
  calc_end_a: assert property (busy && last_step |=> !busy)
    else $error("calculation overran its last step");
  cnt_bound_a: assert property (busy |-> cnt_ff <= `CCU_CALC_CYCLES)
    else $error("step counter out of range");
  whole_word_a: assert property (wr_data |=> word_ff == $past(req_i.wdata))
    else $error("word not captured whole");
  msb_byte_first_a: assert property (wr_data |=> slice == $past(req_i.wdata[31:24]))
    else $error("first slice not the top byte");
  crc_idle_hold_a: assert property (!busy && !wr_reset |=> $stable(crc_ff))
    else $error("checksum moved while idle");
  reload_ones_a: assert property (wr_reset |=> crc_ff == `CCU_DATA_RST)
    else $error("reload did not set ones");

  // --------------------------------------------------------------------------
  // register checks
  // --------------------------------------------------------------------------
  wire at_rst_vals = (crc_ff == `CCU_DATA_RST) && (scratch_ff == `CCU_SCRATCH_RST);
  reload_keep_a: assert property (wr_reset && !wr_scratch |=> $stable(scratch_ff))
    else $error("scratch changed on reload");
  // only a scratch write may move the byte; reloads and data writes must not
  scratch_hold_a: assert property (!wr_scratch |=> $stable(scratch_ff))
    else $error("scratch changed without a write");
  scratch_store_a: assert property (wr_scratch |=> scratch_ff == $past(req_i.wdata[7:0]))
    else $error("scratch byte not stored");
  scratch_upper_a: assert property (rd_scratch |=> rdata_o[31:8] == `CCU_ZERO24)
    else $error("scratch upper bits not zero");
  after_rst_a: assert property ($rose(rstn_i) |-> at_rst_vals)
    else $error("reset values wrong");

  // --------------------------------------------------------------------------
  // coverage
  // --------------------------------------------------------------------------
  write_cov: cover property (wr_data ##5 wr_data);
  stall_cov: cover property (wait_o ##1 wait_o);
  reload_cov: cover property (wr_reset);
  err_cov: cover property (err_o);
  read_after_calc_cov: cover property (wr_data ##5 rd_data);
endmodule // ccu_top

/* File: dv/ccu_master.sv */
/*
  Bus master model for the checksum unit: one task making one word access.
  Assumes ccu_top samples req_i on rising edges of ref_clk_i and stalls with wait_i.
*/
`timescale 1ns/1ps
`include "ccu_defines.svh"
module ccu_master
  import ccu_pkg::*;
(
  // clock and answer
  input  wire logic        ref_clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        wait_i,
  input  wire logic        err_i,
  // request
  output ccu_req_s         req_o
);
  initial req_o = '0;
  // ------------------------------------------------------------------
  // one access
  // ------------------------------------------------------------------
  // released lines carry inverted values so stale data never looks live
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output int waits);
    @(posedge ref_clk_i);
    req_o <= '{sel: 1'b1, write: wr, addr: a, wdata: d};
    waits = 0;
    @(negedge ref_clk_i);
    while (wait_i !== 1'b0 && waits < 20) begin
      waits++;
      @(negedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    req_o <= '{sel: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    #1;
    q = rdata_i;
    e = err_i;
  endtask
endmodule // ccu_master

/* File: dv/ccu_top_tb.sv */
/*
  Self-checking bench for the checksum unit, driven through ccu_master.
  Assumes the register map and reset values of ccu_defines.svh.
*/
`timescale 1ns/1ps
`include "ccu_defines.svh"
module ccu_top_tb
  import ccu_pkg::*;
;
  logic        ref_clk_i;
  logic        rstn_i;
  ccu_req_s    req;
  logic [31:0] rdata;
  logic        wait_w;
  logic        err;
  logic [31:0] q;
  logic [31:0] crc;
  logic        e;
  int          waits;
  int          mismatches;
  int          samples_checked;
  logic [31:0] words [3] = '{32'h00000000, 32'hFFFFFFFF, 32'h12345678};

  ccu_top u_ccu_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req),
                     .rdata_o(rdata), .wait_o(wait_w), .err_o(err));
  ccu_master u_ccu_master (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .wait_i(wait_w),
                           .err_i(err), .req_o(req));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // msb first, no reflection, no final xor
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? `CCU_POLY : 32'h0);
    return c;
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a stall past the bound counts as a mismatch and ends the run
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    u_ccu_master.xfer(wr, a, d, q, e, waits);
    if (waits >= 20) begin
      mismatches++;
      summarize();
    end
  endtask
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    acc(1'b0, `CCU_OFS_DATA, 32'h0);
    chk_word(q, `CCU_DATA_RST);
    acc(1'b0, `CCU_OFS_SCRATCH, 32'h0);
    chk_word(q, 32'h0);
    $display("test reset values done");
    crc = `CCU_DATA_RST;
    foreach (words[i]) begin
      acc(1'b1, `CCU_OFS_DATA, words[i]);
      chk_bit(waits <= 4, 1'b1);
      crc = fold(crc, words[i]);
    end
    acc(1'b0, `CCU_OFS_DATA, 32'h0);
    chk_word(q, crc);
    chk_bit(e, 1'b0);
    $display("test back to back words done");
    acc(1'b1, `CCU_OFS_SCRATCH, 32'hFFFFFF5A);
    acc(1'b0, `CCU_OFS_SCRATCH, 32'h0);
    chk_word(q, 32'h0000005A);
    acc(1'b1, `CCU_OFS_CTRL, 32'h0);
    acc(1'b0, `CCU_OFS_DATA, 32'h0);
    chk_word(q, crc);
    acc(1'b1, `CCU_OFS_CTRL, 32'h1);
    acc(1'b0, `CCU_OFS_DATA, 32'h0);
    chk_word(q, `CCU_DATA_RST);
    acc(1'b0, `CCU_OFS_SCRATCH, 32'h0);
    chk_word(q, 32'h0000005A);
    acc(1'b0, `CCU_OFS_CTRL, 32'h0);
    chk_word(q, 32'h0);
    $display("test reload done");
    // reset in the middle of a calculation: the engine must come back clean
    acc(1'b1, `CCU_OFS_DATA, 32'hA5A5A5A5);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    acc(1'b0, `CCU_OFS_DATA, 32'h0);
    chk_word(q, `CCU_DATA_RST);
    acc(1'b0, `CCU_OFS_SCRATCH, 32'h0);
    chk_word(q, 32'h0);
    $display("test mid-run reset done");
    acc(1'b1, 8'h0C, 32'h1);
    chk_bit(e, 1'b1);
    acc(1'b0, 8'h0C, 32'h0);
    chk_word(q, 32'h0);
    chk_bit(e, 1'b1);
    $display("test unmapped done");
    summarize();
  end
endmodule // ccu_top_tb
